// >>> hw/ccc_chopper.sv
`timescale 1ns/1ps
module ccc_chopper #(
  parameter int OSC_DIV = ccc_pkg::OSC_DIV_DEF,
  parameter int SENSE_W = ccc_pkg::SENSE_W_DEF
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // controller pins
  input wire logic standby_n_in,
  input wire logic phase_in,
  input wire logic fast_decay_in,
  // sensing and fault detectors
  input wire logic overcurrent_in,
  input wire logic thermal_fault_in,
  input wire logic [SENSE_W-1:0] sense_code_in,
  input wire logic [SENSE_W-1:0] vref_code_in,
  // bridge switches
  output logic high_side_switch_one_out,
  output logic high_side_switch_two_out,
  output logic low_side_switch_one_out,
  output logic low_side_switch_two_out,
  // status
  output logic overcurrent_shutdown_out,
  output logic thermal_shutdown_out,
  output logic [1:0] chop_mode_out
);
  localparam int DIV_W = $clog2(OSC_DIV);
  localparam int CHOP_W = $clog2(ccc_pkg::CHOP_OSC_CYC);
  localparam int BLANK_W = $clog2(ccc_pkg::BLANK_CYC + 1);
  localparam int SYNC_W = 5 + 2 * SENSE_W;
  localparam int CHOP_CYC = ccc_pkg::CHOP_OSC_CYC * OSC_DIV;
  localparam int GAP_W = $clog2(CHOP_CYC + 1);
  localparam int OCH_MAX = ccc_pkg::OC_SHUT_MAX_OSC * OSC_DIV;
  localparam int OCH_W = $clog2(OCH_MAX + 1);

  if (OSC_DIV < 2 || SENSE_W < 1) begin : g_bad_param
    $error("ccc_chopper: OSC_DIV must be at least 2 and SENSE_W at least 1");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic standby_s;
  logic phase_s;
  logic fast_s;
  logic oc_s;
  logic tsd_s;
  logic [SENSE_W-1:0] sense_s;
  logic [SENSE_W-1:0] vref_s;

  // one 50 ns pulse spans a full mclk period, so it is always sampled
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {standby_n_in, phase_in, fast_decay_in, overcurrent_in,
                    thermal_fault_in, sense_code_in, vref_code_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign {standby_s, phase_s, fast_s, oc_s, tsd_s, sense_s, vref_s} = sync2_reg;

  // ****************************************
  // chopper control
  // ****************************************
  ccc_pkg::ccc_mode_e mode_reg;
  ccc_pkg::ccc_mode_e mode_next;
  logic [DIV_W-1:0] osc_div_reg;
  logic [DIV_W-1:0] osc_div_next;
  logic [CHOP_W-1:0] chop_cnt_reg;
  logic [CHOP_W-1:0] chop_cnt_next;
  logic [BLANK_W-1:0] blank_reg;
  logic [BLANK_W-1:0] blank_next;
  logic [2:0] oc_cnt_reg;
  logic [2:0] oc_cnt_next;
  logic ocs_reg;
  logic ocs_next;
  logic tsd_reg;
  logic tsd_next;
  logic phase_reg;
  logic phase_next;
  logic [3:0] sw_reg;
  logic [3:0] sw_next;
  logic run;
  logic osc_tick;
  logic period_start;
  logic phase_chg;
  logic at_limit;
  logic [SENSE_W+2:0] sense_x5;

  function automatic logic [3:0] sw_pattern(input ccc_pkg::ccc_mode_e m, input logic fwd);
    logic [3:0] p;
    p = ccc_pkg::SW_OFF;
    unique case (m)
      ccc_pkg::MODE_CHARGE: p = fwd ? ccc_pkg::SW_FWD_CHARGE : ccc_pkg::SW_REV_CHARGE;
      ccc_pkg::MODE_SLOW: p = ccc_pkg::SW_SLOW;
      ccc_pkg::MODE_FAST: p = fwd ? ccc_pkg::SW_FWD_FAST : ccc_pkg::SW_REV_FAST;
      ccc_pkg::MODE_OFF: p = ccc_pkg::SW_OFF;
    endcase
    return p;
  endfunction

  // oscillator stops in standby and in either shutdown
  assign run = standby_s && !ocs_reg && !tsd_reg;
  assign osc_tick = run && (osc_div_reg == DIV_W'(OSC_DIV - 1));
  assign period_start = osc_tick
                        && (chop_cnt_reg == CHOP_W'(ccc_pkg::CHOP_OSC_CYC - 1));
  assign phase_chg = phase_s != phase_reg;
  assign sense_x5 = (SENSE_W + 3)'(sense_s) * (SENSE_W + 3)'(ccc_pkg::VREF_GAIN_DIV);
  assign at_limit = sense_x5 >= {3'h0, vref_s};

  always_comb begin
    mode_next = mode_reg;
    osc_div_next = osc_div_reg;
    chop_cnt_next = chop_cnt_reg;
    blank_next = blank_reg;
    oc_cnt_next = oc_cnt_reg;
    phase_next = phase_s;
    if (!run) begin
      osc_div_next = '0;
      chop_cnt_next = '0;
    end else if (osc_tick) begin
      osc_div_next = '0;
      chop_cnt_next = CHOP_W'(chop_cnt_reg + 1'b1);
    end else begin
      osc_div_next = DIV_W'(osc_div_reg + 1'b1);
    end
    if (blank_reg != '0) begin
      blank_next = BLANK_W'(blank_reg - 1'b1);
    end
    if (!run) begin
      mode_next = ccc_pkg::MODE_OFF;
    end else if (mode_reg == ccc_pkg::MODE_OFF || period_start || phase_chg) begin
      mode_next = ccc_pkg::MODE_CHARGE;
      blank_next = BLANK_W'(ccc_pkg::BLANK_CYC);
    end else if (mode_reg == ccc_pkg::MODE_CHARGE && blank_reg == '0 && at_limit) begin
      mode_next = fast_s ? ccc_pkg::MODE_FAST : ccc_pkg::MODE_SLOW;
      blank_next = BLANK_W'(ccc_pkg::BLANK_CYC);
    end
    if (!oc_s || !run) begin
      oc_cnt_next = '0;
    end else if (osc_tick && oc_cnt_reg != 3'(ccc_pkg::OC_MASK_OSC)) begin
      oc_cnt_next = 3'(oc_cnt_reg + 1'b1);
    end
    ocs_next = standby_s && (ocs_reg || oc_cnt_reg == 3'(ccc_pkg::OC_MASK_OSC));
    tsd_next = standby_s && (tsd_reg || tsd_s);
    sw_next = sw_pattern(mode_next, phase_next);
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mode_reg <= ccc_pkg::MODE_RST;
      osc_div_reg <= '0;
      chop_cnt_reg <= '0;
      blank_reg <= '0;
      oc_cnt_reg <= 3'h0;
      ocs_reg <= 1'b0;
      tsd_reg <= 1'b0;
      phase_reg <= 1'b0;
      sw_reg <= ccc_pkg::SW_OFF;
    end else begin
      mode_reg <= mode_next;
      osc_div_reg <= osc_div_next;
      chop_cnt_reg <= chop_cnt_next;
      blank_reg <= blank_next;
      oc_cnt_reg <= oc_cnt_next;
      ocs_reg <= ocs_next;
      tsd_reg <= tsd_next;
      phase_reg <= phase_next;
      sw_reg <= sw_next;
    end
  end

  assign {high_side_switch_one_out, high_side_switch_two_out,
          low_side_switch_one_out, low_side_switch_two_out} = sw_reg;
  assign overcurrent_shutdown_out = ocs_reg;
  assign thermal_shutdown_out = tsd_reg;
  assign chop_mode_out = mode_reg;

  // ****************************************
  // assertions
  // ****************************************
  logic [GAP_W-1:0] gap_reg;
  logic [OCH_W-1:0] och_reg;

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !run || period_start) begin
      gap_reg <= '0;
    end else begin
      gap_reg <= GAP_W'(gap_reg + 1'b1);
    end
    if (sys_rst_in || !oc_s || !standby_s || !(run || ocs_reg)) begin
      och_reg <= '0;
    end else if (och_reg != OCH_W'(OCH_MAX)) begin
      och_reg <= OCH_W'(och_reg + 1'b1);
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  AST_FWD_PATTERN: assert property (mode_reg == ccc_pkg::MODE_CHARGE && phase_reg
    |-> sw_reg == 4'h9)
    else $error("forward charge pattern wrong");
  AST_FWD_FAST: assert property (mode_reg == ccc_pkg::MODE_FAST && phase_reg
    |-> sw_reg == 4'h6)
    else $error("forward fast pattern wrong");
  AST_REV_CHARGE: assert property (mode_reg == ccc_pkg::MODE_CHARGE && !phase_reg
    |-> sw_reg == 4'h6)
    else $error("reverse charge pattern wrong");
  AST_REV_PATTERN: assert property (mode_reg == ccc_pkg::MODE_FAST && !phase_reg
    |-> sw_reg == 4'h9)
    else $error("reverse fast pattern wrong");
  AST_SLOW_PATTERN: assert property (mode_reg == ccc_pkg::MODE_SLOW |-> sw_reg == 4'h3)
    else $error("slow decay pattern wrong");
  AST_PERIOD_LEN: assert property (period_start |-> gap_reg == GAP_W'(CHOP_CYC - 1))
    else $error("chop period length wrong");
  AST_BLANK_HOLD: assert property (($past(mode_reg) != ccc_pkg::MODE_CHARGE
    && mode_reg == ccc_pkg::MODE_CHARGE && run && !phase_chg) |-> ##1
    (mode_reg == ccc_pkg::MODE_CHARGE || !run || $past(period_start))[*7])
    else $error("charge ended inside blank time");
  AST_THRESHOLD: assert property ((mode_reg == ccc_pkg::MODE_CHARGE && run
    && blank_reg == '0 && at_limit && !period_start && !phase_chg)
    |=> (mode_reg == ccc_pkg::MODE_SLOW || mode_reg == ccc_pkg::MODE_FAST))
    else $error("charge did not end at threshold");
  AST_OC_MASK: assert property ($rose(ocs_reg) |-> och_reg >= OCH_W'(3 * OSC_DIV))
    else $error("overcurrent tripped before masking time");
  AST_OC_BOUND: assert property (och_reg == OCH_W'(OCH_MAX) |-> ocs_reg && sw_reg == 4'h0)
    else $error("overcurrent shutdown too slow");
  AST_OC_LATCH: assert property (ocs_reg && standby_s |=> ocs_reg && sw_reg == 4'h0)
    else $error("overcurrent shutdown not latched");
  AST_TSD_OFF: assert property ((tsd_reg || !standby_s) |=> sw_reg == 4'h0)
    else $error("bridge on during thermal shutdown or standby");
  AST_DECAY_HOLD: assert property ((mode_reg == ccc_pkg::MODE_SLOW
    || mode_reg == ccc_pkg::MODE_FAST) && run && !period_start && !phase_chg
    |=> $stable(mode_reg))
    else $error("decay left before period boundary");
  AST_PERIOD_CHARGE: assert property (period_start |=> mode_reg == ccc_pkg::MODE_CHARGE)
    else $error("period did not start in charge");

  COV_SLOW: cover property (mode_reg == ccc_pkg::MODE_CHARGE ##1 mode_reg == ccc_pkg::MODE_SLOW);
  COV_FAST: cover property (mode_reg == ccc_pkg::MODE_CHARGE ##1 mode_reg == ccc_pkg::MODE_FAST);
  COV_OCS: cover property ($rose(ocs_reg));
  COV_TSD: cover property ($rose(tsd_reg));
endmodule // ccc_chopper

// >>> hw/ccc_pkg.sv
package ccc_pkg;
  // ****************************************
  // clock and reference oscillator
  // ****************************************
  localparam int MCLK_HZ = 20_000_000;
  localparam int MCLK_PERIOD_NS = 50;
  localparam int OSC_HZ = 1_600_000;
  // mclk cycles per reference oscillator cycle, rounded down
  localparam int OSC_DIV_DEF = MCLK_HZ / OSC_HZ;
  localparam int CHOP_OSC_CYC = 16;
  // ****************************************
  // blanking, overcurrent and sensing
  // ****************************************
  localparam int BLANK_NS = 400;
  localparam int BLANK_CYC = (BLANK_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int OC_MASK_OSC = 4;
  localparam int OC_SHUT_MAX_OSC = 8;
  localparam int VREF_GAIN_DIV = 5;
  localparam int SENSE_W_DEF = 8;
  // ****************************************
  // bridge modes and switch patterns
  // ****************************************
  typedef enum logic [1:0] {
    MODE_CHARGE = 2'b00,
    MODE_SLOW = 2'b01,
    MODE_FAST = 2'b10,
    MODE_OFF = 2'b11
  } ccc_mode_e;
  // pattern bit order: high one, high two, low one, low two
  localparam logic [3:0] SW_OFF = 4'h0;
  localparam logic [3:0] SW_FWD_CHARGE = 4'h9;
  localparam logic [3:0] SW_SLOW = 4'h3;
  localparam logic [3:0] SW_FWD_FAST = 4'h6;
  localparam logic [3:0] SW_REV_CHARGE = 4'h6;
  localparam logic [3:0] SW_REV_FAST = 4'h9;
  localparam ccc_mode_e MODE_RST = MODE_OFF;
endpackage

// >>> bench/ccc_winding_model.sv
`timescale 1ns/1ps
// ****************************************
// winding current seen at the sense node
// ****************************************
module ccc_winding_model (
  // clock
  input wire logic mclk_in,
  // bridge state
  input wire logic [1:0] mode_in,
  // sense code
  output logic [7:0] sense_code_out
);
  logic [7:0] level_reg = 8'h00;
  logic [7:0] level_next;
  // current rises while charging and falls in any other state
  always_comb begin
    level_next = level_reg;
    if (mode_in == 2'h0 && level_reg != 8'hff) begin
      level_next = level_reg + 8'h01;
    end else if (mode_in != 2'h0 && level_reg != 8'h00) begin
      level_next = level_reg - 8'h01;
    end
  end
  always_ff @(posedge mclk_in) begin
    level_reg <= level_next;
  end
  assign sense_code_out = level_reg;
endmodule // ccc_winding_model

// >>> bench/test_chopper_current_control.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_chopper_current_control;
  localparam int DIV = 4;
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic standby_n_in = 1'b0;
  logic phase_in = 1'b1;
  logic fast_decay_in = 1'b0;
  logic overcurrent_in = 1'b0;
  logic thermal_fault_in = 1'b0;
  logic use_model = 1'b1;
  logic [7:0] tb_sense = 8'h00;
  logic [7:0] model_sense;
  logic [7:0] sense_code;
  logic [7:0] vref_code = 8'h64;
  logic h1, h2, l1, l2, oc_flag, th_flag;
  logic [1:0] chop_mode;
  logic [3:0] sw;
  int mismatches = 0;
  int cmp_count = 0;
  int n;
  assign sw = {h1, h2, l1, l2};
  assign sense_code = use_model ? model_sense : tb_sense;
  always #25 mclk_in = ~mclk_in;
  ccc_chopper #(.OSC_DIV(DIV), .SENSE_W(8)) u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .standby_n_in(standby_n_in), .phase_in(phase_in), .fast_decay_in(fast_decay_in),
    .overcurrent_in(overcurrent_in), .thermal_fault_in(thermal_fault_in),
    .sense_code_in(sense_code), .vref_code_in(vref_code), .high_side_switch_one_out(h1),
    .high_side_switch_two_out(h2), .low_side_switch_one_out(l1), .low_side_switch_two_out(l2),
    .overcurrent_shutdown_out(oc_flag), .thermal_shutdown_out(th_flag), .chop_mode_out(chop_mode));
  ccc_winding_model u_winding (.mclk_in(mclk_in), .mode_in(chop_mode),
    .sense_code_out(model_sense));
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  task automatic span(input logic [1:0] m, input logic eq, input int max);
    n = 0;
    while ((chop_mode === m) == eq && n < max) begin
      tick(1);
      n++;
    end
  endtask
  task automatic restart(input logic ph, input logic fd);
    @(posedge mclk_in);
    standby_n_in <= 1'b0;
    phase_in <= ph;
    fast_decay_in <= fd;
    tick(4);
    @(posedge mclk_in);
    standby_n_in <= 1'b1;
    tick(1);
    span(2'h0, 1'b0, 8);
    `CHK("start mode", 2'h0, chop_mode)
  endtask
  task automatic regulate();
    restart(1'b1, 1'b0);
    span(2'h0, 1'b1, 64);
    `CHK("decay reached", 2'h1, chop_mode)
    `CHK("peak level", 1'b1, model_sense >= 8'h14)
    span(2'h1, 1'b1, 70);
    `CHK("charge again", 2'h0, chop_mode)
    use_model <= 1'b0;
  endtask
  task automatic mode_pair(input logic ph, input logic fd, input logic [3:0] chg,
                           input logic [1:0] dm, input logic [3:0] dsw);
    int c;
    tb_sense <= 8'h0a;
    vref_code <= 8'h32;
    restart(ph, fd);
    `CHK("charge switches", chg, sw)
    span(2'h0, 1'b0, 70);
    span(2'h0, 1'b1, 20);
    c = n;
    `CHK("blank span", 1'b1, c >= 8)
    `CHK("decay mode", dm, chop_mode)
    `CHK("decay switches", dsw, sw)
    span(dm, 1'b1, 80);
    // first period after wake loses the cycle spent leaving the off state
    span(2'h0, 1'b1, 20);
    c = n;
    span(dm, 1'b1, 80);
    `CHK("period length", 1'b1, (c + n) == 16 * DIV)
  endtask
  task automatic threshold();
    tb_sense <= 8'h09;
    restart(1'b1, 1'b0);
    span(2'h0, 1'b1, 80);
    `CHK("below limit", 80, n)
    @(posedge mclk_in);
    tb_sense <= 8'h0a;
    #1;
    span(2'h0, 1'b1, 10);
    `CHK("at limit", 2'h1, chop_mode)
  endtask
  task automatic overcurrent();
    tb_sense <= 8'h00;
    restart(1'b1, 1'b0);
    @(posedge mclk_in);
    overcurrent_in <= 1'b1;
    tick(2 * DIV);
    @(posedge mclk_in);
    overcurrent_in <= 1'b0;
    tick(3 * DIV);
    `CHK("short glitch", 1'b0, oc_flag)
    @(posedge mclk_in);
    overcurrent_in <= 1'b1;
    n = 0;
    while (oc_flag !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    `CHK("mask time", 1'b1, n >= 3 * DIV)
    `CHK("shutdown bound", 1'b1, n <= 8 * DIV + 3)
    // switches follow the latch by one cycle
    tick(1);
    `CHK("bridge off", 4'h0, sw)
    @(posedge mclk_in);
    overcurrent_in <= 1'b0;
    tick(40);
    `CHK("latched", 1'b1, oc_flag)
    `CHK("latched off", 4'h0, sw)
    restart(1'b1, 1'b0);
    `CHK("recovered", 1'b0, oc_flag)
  endtask
  task automatic thermal();
    @(posedge mclk_in);
    thermal_fault_in <= 1'b1;
    tick(4);
    `CHK("thermal set", 1'b1, th_flag)
    @(posedge mclk_in);
    thermal_fault_in <= 1'b0;
    tick(20);
    `CHK("thermal held", 1'b1, th_flag)
    `CHK("thermal off", 4'h0, sw)
    restart(1'b1, 1'b0);
    `CHK("thermal cleared", 1'b0, th_flag)
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk_in);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    regulate();
    mode_pair(1'b1, 1'b0, 4'h9, 2'h1, 4'h3);
    mode_pair(1'b1, 1'b1, 4'h9, 2'h2, 4'h6);
    mode_pair(1'b0, 1'b0, 4'h6, 2'h1, 4'h3);
    mode_pair(1'b0, 1'b1, 4'h6, 2'h2, 4'h9);
    threshold();
    overcurrent();
    thermal();
    conclude();
  end
endmodule // test_chopper_current_control
